// *** hw/bth_dev.sv ***
// Purpose: processor-side bus termination, halt, double-fault and reset control
// Assumes: link inputs are asynchronous; two-stage synchroniser
// Notes:   terminations are judged once per clock from SAMPLE_FIRST on
// Functional notes
// [RULE_01] halt held stops all activity, else run
// [RULE_02] single step: one bus cycle then stop
// [RULE_03] float address and data after halted cycle
// [RULE_04] halting leaves bus arbitration untouched
// [RULE_05] fault while stacking fault exception halts
// [RULE_06] fault before next instruction is double fault
// [RULE_07] re-run is no fault; repeat while requested
// [RULE_08] fault during vector fetch halts as double
// [RULE_09] double-fault halt left only by reset
// [RULE_10] external logic asserts halt with reset
// [RULE_11] reset loads stack pointer then program counter
// [RULE_12] reset sets mask seven, nothing else
// [RULE_13] reset instruction drives line 124 clocks
// [RULE_14] external reset held ten clocks, power-on longer
// [RULE_15] external inputs change on rising edges
// [RULE_16] outcome from levels at states N, N+2
// [RULE_17] halt with acknowledge: end, stay halted
// [RULE_18] fault without halt: end, take trap
// [RULE_19] fault plus halt: end, re-run after halt
// [RULE_20] fault then later halt still re-runs
// [RULE_21] fault and halt never negated together
// [RULE_22] acknowledge and fault dropped with strobe
// [RULE_23] synchronise every asynchronous input first; read data is taken from link.rdata without the synchroniser
// [RULE_24] re-run repeats cycle; never read-modify-write
module bth_dev (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst,
	bth_if.dev                             link,
	input  wire logic                      i_cyc_req,
	input  wire logic                      i_cyc_wr,
	input  wire logic                      i_cyc_rmw,
	input  wire logic [bth_pkg::ADDR_W-1:0] i_cyc_addr,
	input  wire logic [bth_pkg::DATA_W-1:0] i_cyc_wdata,
	input  wire logic [bth_pkg::FC_W-1:0]   i_cyc_fc,
	input  wire logic                      i_instr_start,
	input  wire logic                      i_reset_instr,
	output logic                           o_cyc_done,
	output logic [bth_pkg::DATA_W-1:0]      o_cyc_rdata,
	output logic                           o_fault_trap,
	output logic                           o_illegal_seq,
	output logic                           o_halted,
	output logic                           o_double_fault,
	output logic                           o_ready,
	output logic [31:0]                    o_sp,
	output logic [31:0]                    o_pc,
	output logic [2:0]                     o_ipl_mask
);
	import bth_pkg::*;

	// synchroniser bit order: ack, fault, halt, reset line
	logic [3:0]        raw_in;
	logic [3:0]        sync1_r;
	logic [3:0]        sync2_r;
	logic              s_ack;
	logic              s_flt;
	logic              s_hlt;
	logic              s_rstl;

	bth_dev_state_t    state_r,    state_nxt;
	logic [2:0]        cnt_r,      cnt_nxt;
	logic              flt_prev_r, flt_prev_nxt;
	logic              rerun_r,    rerun_nxt;
	logic              exc_r,      exc_nxt;
	logic              vec_r,      vec_nxt;
	logic [1:0]        vidx_r,     vidx_nxt;
	logic [31:0]       sp_r,       sp_nxt;
	logic [31:0]       pc_r,       pc_nxt;
	logic [2:0]        ipl_r,      ipl_nxt;
	logic [DATA_W-1:0] rdata_r,    rdata_nxt;
	logic [ADDR_W-1:0] addr_r,     addr_nxt;
	logic [DATA_W-1:0] wdata_r,    wdata_nxt;
	logic [FC_W-1:0]   fc_r,       fc_nxt;
	logic              wr_r,       wr_nxt;
	logic              rmw_r,      rmw_nxt;
	logic [6:0]        rcnt_r,     rcnt_nxt;
	logic              done_r,     done_nxt;
	logic              trap_r,     trap_nxt;
	logic              ill_r,      ill_nxt;
	logic              ext_reset;

	assign raw_in = {link.reset_line, link.halt, link.bus_fault_in, link.transfer_ack_in};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					// halt and reset line read asserted until synchronised
					sync1_r[gi] <= 1'(gi >= 2);
					sync2_r[gi] <= 1'(gi >= 2);
				end else begin
					sync1_r[gi] <= raw_in[gi]; // RULE_23
					sync2_r[gi] <= sync1_r[gi]; // RULE_23
				end
			end
		end
	endgenerate

	assign s_ack  = sync2_r[0];
	assign s_flt  = sync2_r[1];
	assign s_hlt  = sync2_r[2];
	assign s_rstl = sync2_r[3];

	// own reset drive must not reset us
	assign ext_reset = s_rstl & s_hlt & (state_r != ST_RSTOUT); // RULE_10

	always_comb begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		flt_prev_nxt = flt_prev_r;
		rerun_nxt    = rerun_r;
		exc_nxt      = exc_r;
		vec_nxt      = vec_r;
		vidx_nxt     = vidx_r;
		sp_nxt       = sp_r;
		pc_nxt       = pc_r;
		ipl_nxt      = ipl_r;
		rdata_nxt    = rdata_r;
		addr_nxt     = addr_r;
		wdata_nxt    = wdata_r;
		fc_nxt       = fc_r;
		wr_nxt       = wr_r;
		rmw_nxt      = rmw_r;
		rcnt_nxt     = rcnt_r;
		done_nxt     = 1'b0;
		trap_nxt     = 1'b0;
		ill_nxt      = 1'b0;
		if (ext_reset) begin
			state_nxt = ST_RESET; // RULE_09
			ipl_nxt   = IPL_RESET; // RULE_12
		end else begin
			case (state_r)
				ST_RESET: begin
					state_nxt = ST_VECTOR;
					vec_nxt   = 1'b1;
					vidx_nxt  = 2'h0;
					exc_nxt   = 1'b1; // RULE_08
				end
				ST_VECTOR: begin
					if (!s_hlt) begin
						state_nxt    = ST_CYCLE;
						addr_nxt     = {{(ADDR_W-3){1'b0}}, vidx_r, 1'b0}; // RULE_11
						fc_nxt       = FC_SUPER_PROG;
						wr_nxt       = 1'b0;
						rmw_nxt      = 1'b0;
						cnt_nxt      = 3'h0;
						flt_prev_nxt = 1'b0;
					end
				end
				ST_IDLE: begin
					if (i_instr_start) begin
						exc_nxt = 1'b0; // RULE_06
					end
					if (!s_hlt) begin // RULE_01
						if (i_reset_instr) begin
							state_nxt = ST_RSTOUT;
							rcnt_nxt  = 7'h00;
						end else if (i_cyc_req) begin
							state_nxt    = ST_CYCLE;
							addr_nxt     = i_cyc_addr;
							wdata_nxt    = i_cyc_wdata;
							fc_nxt       = i_cyc_fc;
							wr_nxt       = i_cyc_wr;
							rmw_nxt      = i_cyc_rmw;
							cnt_nxt      = 3'h0;
							flt_prev_nxt = 1'b0;
						end
					end
				end
				ST_CYCLE: begin
					if (cnt_r < SAMPLE_FIRST) begin
						cnt_nxt = cnt_r + 3'h1;
					end else if (s_hlt && (s_flt || flt_prev_r) && !rmw_r) begin
						state_nxt = ST_HALT; // RULE_19 RULE_20
						rerun_nxt = 1'b1; // RULE_07
					end else if (s_flt && (flt_prev_r || s_hlt)) begin
						// fault seen twice, or re-run refused
						trap_nxt  = 1'b1; // RULE_18 RULE_24
						state_nxt = exc_r ? ST_DOUBLE : ST_IDLE; // RULE_05 RULE_06 RULE_08
						exc_nxt   = 1'b1;
						vec_nxt   = 1'b0;
					end else if (s_flt) begin
						flt_prev_nxt = 1'b1; // RULE_16
					end else if (s_ack) begin
						rdata_nxt = link.rdata; // RULE_16
						if (vec_r) begin
							case (vidx_r)
								2'h0:    sp_nxt[31:16] = link.rdata;
								2'h1:    sp_nxt[15:0]  = link.rdata;
								2'h2:    pc_nxt[31:16]  = link.rdata;
								default: pc_nxt[15:0]   = link.rdata; // RULE_11
							endcase
							vidx_nxt = vidx_r + 2'h1;
							if (vidx_r == VEC_LAST_WORD) begin
								vec_nxt = 1'b0;
							end
						end else begin
							done_nxt = 1'b1;
						end
						rerun_nxt = 1'b0;
						if (s_hlt) begin
							state_nxt = ST_HALT; // RULE_17 RULE_02
						end else if (vec_r && vidx_r != VEC_LAST_WORD) begin
							state_nxt = ST_VECTOR;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				ST_HALT: begin
					flt_prev_nxt = s_flt;
					if (!s_hlt) begin
						if (rerun_r && flt_prev_r && !s_flt) begin
							// fault and halt dropped in the same state
							ill_nxt   = 1'b1; // RULE_21
							rerun_nxt = 1'b0;
							vec_nxt   = 1'b0;
							state_nxt = ST_IDLE;
						end else if (rerun_r) begin
							state_nxt    = ST_CYCLE; // RULE_24
							rerun_nxt    = 1'b0;
							cnt_nxt      = 3'h0;
							flt_prev_nxt = 1'b0;
						end else begin
							state_nxt = vec_r ? ST_VECTOR : ST_IDLE; // RULE_01
						end
					end
				end
				ST_DOUBLE: begin
					state_nxt = ST_DOUBLE; // RULE_09
				end
				ST_RSTOUT: begin
					rcnt_nxt = rcnt_r + 7'h01;
					if (rcnt_r == 7'(RESET_INSTR_CLKS - 1)) begin
						state_nxt = ST_IDLE; // RULE_13
					end
				end
				default: begin
					state_nxt = ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_r    <= ST_RESET;
			cnt_r      <= 3'h0;
			flt_prev_r <= 1'b0;
			rerun_r    <= 1'b0;
			exc_r      <= 1'b1;
			vec_r      <= 1'b0;
			vidx_r     <= 2'h0;
			sp_r       <= 32'h0000_0000;
			pc_r       <= 32'h0000_0000;
			ipl_r      <= IPL_RESET;
			rdata_r    <= '0;
			addr_r     <= '0;
			wdata_r    <= '0;
			fc_r       <= '0;
			wr_r       <= 1'b0;
			rmw_r      <= 1'b0;
			rcnt_r     <= 7'h00;
			done_r     <= 1'b0;
			trap_r     <= 1'b0;
			ill_r      <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			flt_prev_r <= flt_prev_nxt;
			rerun_r    <= rerun_nxt;
			exc_r      <= exc_nxt;
			vec_r      <= vec_nxt;
			vidx_r     <= vidx_nxt;
			sp_r       <= sp_nxt;
			pc_r       <= pc_nxt;
			ipl_r      <= ipl_nxt;
			rdata_r    <= rdata_nxt;
			addr_r     <= addr_nxt;
			wdata_r    <= wdata_nxt;
			fc_r       <= fc_nxt;
			wr_r       <= wr_nxt;
			rmw_r      <= rmw_nxt;
			rcnt_r     <= rcnt_nxt;
			done_r     <= done_nxt;
			trap_r     <= trap_nxt;
			ill_r      <= ill_nxt;
		end
	end

	// address and data float outside a cycle
	assign link.addr              = addr_r;
	assign link.addr_oe           = (state_r == ST_CYCLE); // RULE_03 RULE_04
	assign link.wdata             = wdata_r;
	assign link.data_oe           = (state_r == ST_CYCLE) & wr_r; // RULE_03
	assign link.fc                = fc_r;
	assign link.wr                = wr_r;
	assign link.addr_valid_strobe = (state_r == ST_CYCLE) && (cnt_r != 3'h0);
	assign link.dev_rst_out       = 1'b1;
	assign link.dev_rst_oe        = (state_r == ST_RSTOUT); // RULE_13

	assign o_cyc_done     = done_r;
	assign o_cyc_rdata    = rdata_r;
	assign o_fault_trap   = trap_r;
	assign o_illegal_seq  = ill_r;
	assign o_halted       = (state_r == ST_HALT) || (state_r == ST_DOUBLE) ||
	                        ((state_r == ST_IDLE) && s_hlt);
	assign o_double_fault = (state_r == ST_DOUBLE);
	assign o_ready        = (state_r == ST_IDLE) && !s_hlt;
	assign o_sp           = sp_r;
	assign o_pc           = pc_r;
	assign o_ipl_mask     = ipl_r;
endmodule : bth_dev

// *** shared/bth_pkg.sv ***
// Purpose: shared constants and types for the bus termination, halt and reset link
// Assumes: one 25 MHz clock, positive-logic link signals (1 = asserted)
// Notes:   power-on hold count follows from its time and the clock rate
package bth_pkg;
	localparam int unsigned CLK_HZ            = 25_000_000;
	localparam int unsigned ADDR_W            = 24;
	localparam int unsigned DATA_W            = 16;
	localparam int unsigned FC_W              = 3;
	// two-stage input synchroniser on the device
	localparam int unsigned SYNC_STAGES       = 2;
	// first count that samples terminations
	localparam logic [2:0]  SAMPLE_FIRST      = 3'h3;
	localparam logic [2:0]  IPL_RESET         = 3'h7;
	localparam logic [2:0]  FC_SUPER_PROG     = 3'h6;
	localparam logic [1:0]  VEC_LAST_WORD     = 2'h3;
	localparam int unsigned RESET_INSTR_CLKS  = 124;
	localparam int unsigned RESET_MIN_CLKS    = 10;
	localparam int unsigned POWERON_MS        = 100;
	localparam int unsigned POWERON_CLKS      = (CLK_HZ / 1000) * POWERON_MS;
	localparam int unsigned HOLD_CNT_W        = 22;

	typedef enum logic [1:0] {
		TERM_NORMAL = 2'h0,
		TERM_FAULT  = 2'h1,
		TERM_HALT   = 2'h2,
		TERM_RERUN  = 2'h3
	} bth_term_t;

	typedef enum logic [6:0] {
		ST_RESET  = 7'h01,
		ST_VECTOR = 7'h02,
		ST_IDLE   = 7'h04,
		ST_CYCLE  = 7'h08,
		ST_HALT   = 7'h10,
		ST_DOUBLE = 7'h20,
		ST_RSTOUT = 7'h40
	} bth_dev_state_t;

	typedef enum logic [4:0] {
		HS_POWERON = 5'h01,
		HS_RESET   = 5'h02,
		HS_READY   = 5'h04,
		HS_RESP    = 5'h08,
		HS_TAIL    = 5'h10
	} bth_host_state_t;
endpackage : bth_pkg

// *** shared/bth_if.sv ***
// Purpose: link between the processor end and the external control logic
// Assumes: positive logic; reset line resolved from both ends' enables
// Notes:   the reset line reads asserted while either end drives it
interface bth_if;
	import bth_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic              addr_oe;
	logic [DATA_W-1:0] wdata;
	logic              data_oe;
	logic [DATA_W-1:0] rdata;
	logic [FC_W-1:0]   fc;
	logic              wr;
	logic              addr_valid_strobe;
	logic              transfer_ack_in;
	logic              bus_fault_in;
	logic              halt;
	logic              dev_rst_out;
	logic              dev_rst_oe;
	logic              host_rst_out;
	logic              host_rst_oe;
	logic              reset_line;

	assign reset_line = (dev_rst_oe & dev_rst_out) | (host_rst_oe & host_rst_out);

	modport dev (
		output addr, addr_oe, wdata, data_oe, fc, wr, addr_valid_strobe,
		output dev_rst_out, dev_rst_oe,
		input  rdata, transfer_ack_in, bus_fault_in, halt, reset_line
	);
	modport host (
		input  addr, addr_oe, wdata, data_oe, fc, wr, addr_valid_strobe, reset_line,
		output rdata, transfer_ack_in, bus_fault_in, halt, host_rst_out, host_rst_oe
	);
endinterface : bth_if

// *** hw/bth_host.sv ***
// Purpose: external bus-control, reset and debugger end of the link
// Assumes: link inputs synchronous; link outputs registered
// Notes:   termination kind for each cycle is chosen by i_term_mode at strobe
module bth_host #(
	parameter int unsigned POWERON_CLKS = bth_pkg::POWERON_CLKS
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	bth_if.host                             link,
	input  wire logic                       i_cmd_reset,
	input  wire logic                       i_halt_req,
	input  wire logic                       i_step,
	input  wire bth_pkg::bth_term_t          i_term_mode,
	input  wire logic [bth_pkg::DATA_W-1:0]  i_rdata,
	output logic                            o_cyc_seen,
	output logic [bth_pkg::ADDR_W-1:0]       o_addr_seen,
	output logic [bth_pkg::DATA_W-1:0]       o_wdata_seen,
	output logic                            o_reset_active,
	output logic                            o_dev_reset_seen
);
	import bth_pkg::*;

	bth_host_state_t       state_r, state_nxt;
	logic [HOLD_CNT_W-1:0] cnt_r,   cnt_nxt;
	logic                  ack_r,   ack_nxt;
	logic                  flt_r,   flt_nxt;
	logic                  thlt_r,  thlt_nxt;
	logic                  halt_r,  halt_nxt;
	logic                  step_r,  step_nxt;
	logic                  seen_r,  seen_nxt;
	logic [ADDR_W-1:0]     addr_r,  addr_nxt;
	logic [DATA_W-1:0]     wdat_r,  wdat_nxt;
	logic [DATA_W-1:0]     rdat_r,  rdat_nxt;
	logic                  holding;

	assign holding = (state_r == HS_POWERON) || (state_r == HS_RESET);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		ack_nxt   = ack_r;
		flt_nxt   = flt_r;
		thlt_nxt  = thlt_r;
		step_nxt  = step_r;
		seen_nxt  = 1'b0;
		addr_nxt  = addr_r;
		wdat_nxt  = wdat_r;
		rdat_nxt  = rdat_r;
		case (state_r)
			HS_POWERON, HS_RESET: begin
				cnt_nxt = cnt_r + 1'b1;
				if ((state_r == HS_POWERON && cnt_r == HOLD_CNT_W'(POWERON_CLKS - 1)) ||
				    (state_r == HS_RESET && cnt_r == HOLD_CNT_W'(RESET_MIN_CLKS - 1))) begin
					state_nxt = HS_READY; // RULE_14
				end
			end
			HS_READY: begin
				if (i_step && i_halt_req) begin
					step_nxt = 1'b1;
				end
				if (link.addr_valid_strobe) begin
					state_nxt = HS_RESP;
					step_nxt  = 1'b0; // RULE_02
					seen_nxt  = 1'b1;
					addr_nxt  = link.addr;
					wdat_nxt  = link.wdata;
					rdat_nxt  = i_rdata;
					ack_nxt   = (i_term_mode != TERM_RERUN);
					flt_nxt   = (i_term_mode == TERM_FAULT) || (i_term_mode == TERM_RERUN);
					thlt_nxt  = (i_term_mode == TERM_HALT) || (i_term_mode == TERM_RERUN); // RULE_19
				end
			end
			HS_RESP: begin
				if (!link.addr_valid_strobe) begin
					ack_nxt   = 1'b0; // RULE_22
					flt_nxt   = 1'b0; // RULE_22
					state_nxt = (flt_r && thlt_r) ? HS_TAIL : HS_READY;
					thlt_nxt  = flt_r && thlt_r;
				end
			end
			HS_TAIL: begin
				// halt outlives fault by one clock
				thlt_nxt  = 1'b0; // RULE_19 RULE_21
				state_nxt = HS_READY;
			end
			default: begin
				state_nxt = HS_READY;
			end
		endcase
		if (i_cmd_reset) begin
			state_nxt = HS_RESET;
			cnt_nxt   = '0;
			ack_nxt   = 1'b0;
			flt_nxt   = 1'b0;
			thlt_nxt  = 1'b0;
			step_nxt  = 1'b0;
		end
		halt_nxt = (state_nxt == HS_POWERON) || (state_nxt == HS_RESET) || thlt_nxt ||
		           (i_halt_req && !step_nxt); // RULE_10 RULE_01
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_r <= HS_POWERON;
			cnt_r   <= '0;
			ack_r   <= 1'b0;
			flt_r   <= 1'b0;
			thlt_r  <= 1'b0;
			halt_r  <= 1'b1;
			step_r  <= 1'b0;
			seen_r  <= 1'b0;
			addr_r  <= '0;
			wdat_r  <= '0;
			rdat_r  <= '0;
		end else begin
			// link outputs change only here
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			ack_r   <= ack_nxt; // RULE_15
			flt_r   <= flt_nxt; // RULE_15
			thlt_r  <= thlt_nxt;
			halt_r  <= halt_nxt; // RULE_15
			step_r  <= step_nxt;
			seen_r  <= seen_nxt;
			addr_r  <= addr_nxt;
			wdat_r  <= wdat_nxt;
			rdat_r  <= rdat_nxt;
		end
	end

	assign link.transfer_ack_in = ack_r;
	assign link.bus_fault_in    = flt_r;
	assign link.halt            = halt_r;
	assign link.rdata           = rdat_r;
	assign link.host_rst_out    = 1'b1;
	assign link.host_rst_oe     = holding; // RULE_10 RULE_14

	assign o_cyc_seen       = seen_r;
	assign o_addr_seen      = addr_r;
	assign o_wdata_seen     = wdat_r;
	assign o_reset_active   = holding;
	assign o_dev_reset_seen = link.reset_line && !holding;
endmodule : bth_host

// *** verif/bth_assertions.sv ***
// Purpose: link checks between the processor end and the control end
// Assumes: positive-logic link, one clock, synchronous active-high reset
// Notes:   sees only interface signals; instantiated beside the interface
module bth_assertions (
	input wire logic                       i_clk_sys,
	input wire logic                       i_rst,
	input wire logic [bth_pkg::ADDR_W-1:0] addr,
	input wire logic                       addr_oe,
	input wire logic [bth_pkg::DATA_W-1:0] wdata,
	input wire logic                       data_oe,
	input wire logic [bth_pkg::FC_W-1:0]   fc,
	input wire logic                       wr,
	input wire logic                       addr_valid_strobe,
	input wire logic                       transfer_ack_in,
	input wire logic                       bus_fault_in,
	input wire logic                       halt,
	input wire logic                       dev_rst_oe,
	input wire logic                       host_rst_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import bth_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic [7:0]                    drv_r, drv_nxt;
	logic [2:0]                    vec_r, vec_nxt;
	logic                          sv_r;
	logic                          rr_r, rr_nxt;
	logic [ADDR_W+FC_W+DATA_W:0]   cy_r, cy_nxt;
	// reset drive length, vector count, cycle a re-run repeats
	always_comb begin
		drv_nxt = dev_rst_oe ? drv_r + 8'h01 : 8'h00;
		vec_nxt = vec_r;
		rr_nxt = rr_r;
		cy_nxt = cy_r;
		if (host_rst_oe && halt) begin
			vec_nxt = 3'h0;
		end else if (addr_valid_strobe && !sv_r && vec_r != 3'h4) begin
			vec_nxt = vec_r + 3'h1;
		end
		if (sv_r && !addr_valid_strobe) begin
			rr_nxt = halt && bus_fault_in;
			cy_nxt = {addr, fc, wr, wr ? wdata : {DATA_W{1'b0}}};
		end else if (addr_valid_strobe && !sv_r) begin
			rr_nxt = 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			drv_r <= 8'h00;
			vec_r <= 3'h0;
			sv_r <= 1'b0;
			rr_r <= 1'b0;
			cy_r <= '0;
		end else begin
			drv_r <= drv_nxt;
			vec_r <= vec_nxt;
			sv_r <= addr_valid_strobe;
			rr_r <= rr_nxt;
			cy_r <= cy_nxt;
		end
	end
	sequence s_start;
		$rose(addr_valid_strobe);
	endsequence
	sequence s_hold3;
		addr_valid_strobe [*3];
	endsequence
	property p_strobe_min;
		s_start |-> s_hold3;
	endproperty
	property p_ack_ends;
		addr_valid_strobe && transfer_ack_in |-> ##[1:6] !addr_valid_strobe;
	endproperty
	property p_fault_ends;
		addr_valid_strobe && bus_fault_in |-> ##[1:8] !addr_valid_strobe;
	endproperty
	property p_float;
		$fell(addr_valid_strobe) && halt |-> !addr_oe && !data_oe;
	endproperty
	property p_halt_blocks;
		halt [*3] |=> !$rose(addr_oe);
	endproperty
	property p_rst_drive;
		$fell(dev_rst_oe) |-> drv_r == 8'(RESET_INSTR_CLKS);
	endproperty
	property p_vector;
		s_start ##0 (vec_r < 3'h4) |-> addr == ADDR_W'({vec_r, 1'b0}) && fc == FC_SUPER_PROG && !wr;
	endproperty
	property p_rerun_same;
		s_start ##0 rr_r |-> {addr, fc, wr, wr ? wdata : {DATA_W{1'b0}}} == cy_r;
	endproperty
	a_strobe_min: assert property (p_strobe_min) else $error("strobe too short");
	a_ack_ends: assert property (p_ack_ends) else $error("ack did not end cycle");
	a_fault_ends: assert property (p_fault_ends) else $error("fault did not end cycle");
	a_float: assert property (p_float) else $error("bus not floated");
	a_halt_blocks: assert property (p_halt_blocks) else $error("cycle under halt");
	a_rst_drive: assert property (p_rst_drive) else $error("reset drive length");
	a_vector: assert property (p_vector) else $error("vector fetch order");
	a_rerun_same: assert property (p_rerun_same) else $error("re-run differs");
endmodule : bth_assertions

// *** verif/bus_termination_halt_reset_tb.sv ***
// Purpose: drives both link ends from their user sides and checks outcomes
// Assumes: control end power-on hold shortened to 20 clocks
// Notes:   read data mirrors the low address byte so vectors are traceable
module bus_termination_halt_reset_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bth_pkg::*;
	typedef struct packed {
		logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; bth_term_t t; logic trp;
	} bth_row_t;
	bth_row_t rows [4] = '{'{1'b0, 24'h000100, 16'h0000, TERM_NORMAL, 1'b0},
		'{1'b1, 24'h000202, 16'hBEEF, TERM_NORMAL, 1'b0},
		'{1'b0, 24'h000304, 16'h0000, TERM_FAULT, 1'b1},
		'{1'b0, 24'h0001FE, 16'h0000, TERM_NORMAL, 1'b0}};
	logic              i_clk_sys = 1'b0;
	logic              i_rst = 1'b1;
	logic              req = 1'b0, wr = 1'b0, rmw = 1'b0, ist = 1'b0, rsi = 1'b0;
	logic              cmd = 1'b0, hreq = 1'b0, step = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wd = '0, rdi = '0;
	logic [FC_W-1:0]   fc = '0;
	bth_term_t         term = TERM_NORMAL;
	logic              done, trap, ill, halted, dbl, ready, seen, ract, dseen;
	logic [DATA_W-1:0] rd, wseen;
	logic [ADDR_W-1:0] aseen;
	logic [31:0]       sp, pc;
	logic [2:0]        ipl;
	int                n_mismatch = 0, comparisons = 0, n_done = 0, n_trap = 0, n_seen = 0;
	int                b_d, b_t, b_s, k;
	bth_if link_if();
	bth_dev u_bth_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link_if), .i_cyc_req(req),
		.i_cyc_wr(wr), .i_cyc_rmw(rmw), .i_cyc_addr(addr), .i_cyc_wdata(wd), .i_cyc_fc(fc),
		.i_instr_start(ist), .i_reset_instr(rsi), .o_cyc_done(done), .o_cyc_rdata(rd),
		.o_fault_trap(trap), .o_illegal_seq(ill), .o_halted(halted), .o_double_fault(dbl),
		.o_ready(ready), .o_sp(sp), .o_pc(pc), .o_ipl_mask(ipl));
	bth_host #(.POWERON_CLKS(20)) u_bth_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.link(link_if), .i_cmd_reset(cmd), .i_halt_req(hreq), .i_step(step),
		.i_term_mode(term), .i_rdata(rdi), .o_cyc_seen(seen), .o_addr_seen(aseen),
		.o_wdata_seen(wseen), .o_reset_active(ract), .o_dev_reset_seen(dseen));
	bth_assertions u_bth_assertions (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.addr(link_if.addr), .addr_oe(link_if.addr_oe), .wdata(link_if.wdata),
		.data_oe(link_if.data_oe), .fc(link_if.fc), .wr(link_if.wr),
		.addr_valid_strobe(link_if.addr_valid_strobe), .transfer_ack_in(link_if.transfer_ack_in),
		.bus_fault_in(link_if.bus_fault_in), .halt(link_if.halt),
		.dev_rst_oe(link_if.dev_rst_oe), .host_rst_oe(link_if.host_rst_oe));
	always #20 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) rdi <= {8'hA5, link_if.addr[7:0]};
	always @(negedge i_clk_sys) begin
		if (done === 1'b1) n_done++;
		if (trap === 1'b1) n_trap++;
		if (seen === 1'b1) n_seen++;
	end
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic idle(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask : idle
	task automatic instr();
		@(posedge i_clk_sys) ist <= 1'b1;
		@(posedge i_clk_sys) ist <= 1'b0;
	endtask : instr
	task automatic wait_ready();
		for (int j = 0; j < 3000 && ready !== 1'b1; j++) @(negedge i_clk_sys);
	endtask : wait_ready
	task automatic run_cyc(input logic w, input logic m, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input bth_term_t t);
		@(posedge i_clk_sys);
		req <= 1'b1;
		wr <= w;
		rmw <= m;
		addr <= a;
		wd <= d;
		fc <= 3'h5;
		term <= t;
		for (int j = 0; j < 100 && link_if.addr_valid_strobe !== 1'b1; j++) @(negedge i_clk_sys);
		@(posedge i_clk_sys);
		req <= 1'b0;
		term <= TERM_NORMAL;
		for (int j = 0; j < 100 && link_if.addr_valid_strobe === 1'b1; j++) @(negedge i_clk_sys);
		idle(6);
	endtask : run_cyc
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20) @(negedge i_clk_sys);
		check("ipl in reset", 32'(ipl), 32'h7);
		@(posedge i_clk_sys) i_rst <= 1'b0;
		idle(3);
		check("power-on reset", 32'(link_if.reset_line && link_if.halt), 32'h1);
		wait_ready();
		check("sp", sp, 32'hA500A502);
		check("pc", pc, 32'hA504A506);
		check("ipl", 32'(ipl), 32'h7);
		foreach (rows[i]) begin
			instr();
			b_d = n_done;
			b_t = n_trap;
			run_cyc(rows[i].w, 1'b0, rows[i].a, rows[i].d, rows[i].t);
			check("trap", 32'(n_trap - b_t), 32'(rows[i].trp));
			check("addr", 32'(aseen), 32'(rows[i].a));
			if (!rows[i].trp) begin
				check("done", 32'(n_done - b_d), 32'h1);
				check("data", rows[i].w ? wseen : rd, rows[i].w ? rows[i].d : {8'hA5, rows[i].a[7:0]});
			end
		end
		// re-run of a write, then a normal ending
		b_d = n_done;
		b_t = n_trap;
		b_s = n_seen;
		run_cyc(1'b1, 1'b0, 24'h000A0C, 16'h5A5A, TERM_RERUN);
		for (k = 0; k < 100 && n_done == b_d; k++) @(negedge i_clk_sys);
		idle(4);
		check("rerun seen", 32'(n_seen - b_s), 32'h2);
		check("rerun trap", 32'(n_trap - b_t), 32'h0);
		check("rerun done", 32'(n_done - b_d), 32'h1);
		check("rerun data", 32'(wseen), 32'h5A5A);
		// halt held, then one single step
		@(posedge i_clk_sys) hreq <= 1'b1;
		idle(10);
		b_s = n_seen;
		b_d = n_done;
		@(posedge i_clk_sys) req <= 1'b1;
		idle(30);
		check("halt blocks", 32'(n_seen - b_s), 32'h0);
		check("halted", 32'(halted), 32'h1);
		@(posedge i_clk_sys) step <= 1'b1;
		@(posedge i_clk_sys) step <= 1'b0;
		for (k = 0; k < 100 && n_seen == b_s; k++) @(negedge i_clk_sys);
		@(posedge i_clk_sys) req <= 1'b0;
		idle(40);
		check("step seen", 32'(n_seen - b_s), 32'h1);
		check("step done", 32'(n_done - b_d), 32'h1);
		@(posedge i_clk_sys) hreq <= 1'b0;
		idle(10);
		check("run", 32'(ready), 32'h1);
		// two faults with no instruction between
		instr();
		run_cyc(1'b0, 1'b0, 24'h000C00, 16'h0000, TERM_FAULT);
		run_cyc(1'b0, 1'b0, 24'h000C02, 16'h0000, TERM_FAULT);
		check("double", 32'(dbl), 32'h1);
		b_s = n_seen;
		@(posedge i_clk_sys) req <= 1'b1;
		idle(30);
		check("dead", 32'(n_seen - b_s), 32'h0);
		@(posedge i_clk_sys) req <= 1'b0;
		@(posedge i_clk_sys) cmd <= 1'b1;
		@(posedge i_clk_sys) cmd <= 1'b0;
		idle(5);
		wait_ready();
		check("restart", 32'(dbl), 32'h0);
		check("sp again", sp, 32'hA500A502);
		// reset instruction drives the line and keeps registers
		@(posedge i_clk_sys) rsi <= 1'b1;
		@(posedge i_clk_sys) rsi <= 1'b0;
		for (k = 0; k < 20 && link_if.reset_line !== 1'b1; k++) @(negedge i_clk_sys);
		check("dev reset seen", 32'(dseen), 32'h1);
		for (k = 0; k < 300 && link_if.reset_line === 1'b1; k++) @(negedge i_clk_sys);
		check("drive clocks", 32'(k), 32'(RESET_INSTR_CLKS));
		idle(5);
		check("pc kept", pc, 32'hA504A506);
		check("ready kept", 32'(ready), 32'h1);
		// read-modify-write asked to re-run becomes a trap
		instr();
		b_t = n_trap;
		b_s = n_seen;
		run_cyc(1'b0, 1'b1, 24'h000D00, 16'h0000, TERM_RERUN);
		idle(30);
		check("rmw trap", 32'(n_trap - b_t), 32'h1);
		check("rmw once", 32'(n_seen - b_s), 32'h1);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_mismatch++;
		test_done();
	end
endmodule : bus_termination_halt_reset_tb
